// ### design/io_station_pkg.sv
/*
 Shared constants for the I/O station supervisor.
 Assumes a 125 MHz clock; link bytes arrive already deserialised.
*/
package io_station_pkg;
    localparam int unsigned clk_mhz = 125;
    localparam int unsigned scan_period_us = 1000;
    localparam int unsigned scan_period_cycles = scan_period_us * clk_mhz;
    localparam int unsigned comm_timeout_us = 100000;
    localparam int unsigned comm_timeout_cycles = comm_timeout_us * clk_mhz;
    localparam int unsigned flash_ms = 50;
    localparam int unsigned flash_cycles = flash_ms * 1000 * clk_mhz;
    localparam int unsigned chan_count = 16;
    localparam int unsigned addr_width = 6;
    localparam int unsigned ram_words = 64;
    localparam int unsigned msg_len = 18;
    localparam logic [7:0] ram_pattern = 8'ha5;
    localparam logic [7:0] rom_sum_expected = 8'h00;
    localparam logic [7:0] resp_marker = 8'h5a;
endpackage

// ### design/io_station_supervisor.sv
/*
 I/O station supervisor: init with memory tests, timed scans, idle RAM test,
 link command handling with response, indicators.
 Assumes byte-level receive/transmit strobes from serial logic outside.
*/
`timescale 1ns/1ps
module io_station_supervisor #(
    parameter int unsigned chans = io_station_pkg::chan_count,
    parameter int unsigned scan_cycles = io_station_pkg::scan_period_cycles,
    parameter int unsigned timeout_cycles = io_station_pkg::comm_timeout_cycles,
    parameter int unsigned flash_len = io_station_pkg::flash_cycles
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic pushbutton_reset,
    input wire logic [7:0] station_address,
    input wire logic [7:0] rom_data,
    output logic [7:0] rom_addr,
    input wire logic rx_valid_a,
    input wire logic rx_valid_b,
    input wire logic [7:0] rx_byte_a,
    input wire logic [7:0] rx_byte_b,
    input wire logic rx_end,
    output logic tx_valid,
    output logic [7:0] tx_byte,
    input wire logic tx_ready,
    input wire logic [chans-1:0] input_channels,
    output logic [chans-1:0] output_channels,
    output logic serial_setup,
    output logic halted,
    output logic running,
    output logic channel_select_indicator,
    output logic link_colour_red,
    output logic link_colour_green,
    output logic transmit_activity_indicator,
    output logic receive_activity_indicator,
    output logic tx_activity_a,
    output logic rx_activity_a,
    output logic tx_activity_b,
    output logic rx_activity_b
);
    typedef enum logic [3:0] {
        st_hw_init = 4'h0,
        st_ram_test = 4'h1,
        st_rom_test = 4'h2,
        st_comm_setup = 4'h3,
        st_find_link = 4'h4,
        st_main = 4'h5,
        st_scan = 4'h6,
        st_halt = 4'h7,
        st_respond = 4'h8
    } phase_e;

    typedef struct packed {
        phase_e phase;
        logic [6:0] idx;
        logic [7:0] sum;
        logic chan_b;
        logic [31:0] scan_timer;
        logic [31:0] comm_timer;
        logic [7:0] rx_count;
        logic rx_addr_ok;
        logic rx_bad;
        logic [7:0] rx_check;
        logic [5:0] idle_idx;
        logic idle_write;
        logic [chans-1:0] in_image;
        logic [chans-1:0] out_image;
        logic [31:0] tx_flash;
        logic [31:0] rx_flash;
        logic tx_busy;
        logic [7:0] tx_idx;
    } state_s;

    // Whole supervisor state, one register copy
    state_s cur;
    state_s nxt;
    // Scratch RAM under test; only ever holds the address-keyed pattern
    logic [7:0] ram [io_station_pkg::ram_words];
    logic ram_we;
    logic [io_station_pkg::addr_width-1:0] ram_waddr;
    logic [7:0] ram_wdata;
    // Rebuilt at every scan, so a poll never waits on a fresh capture
    logic [7:0] resp [io_station_pkg::msg_len];
    logic [7:0] cmd [io_station_pkg::msg_len];
    logic resp_build;
    logic cmd_we;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic restart;

    function automatic logic [7:0] img_byte(input logic [chans-1:0] img, input int unsigned n);
        logic [7:0] b;
        b = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (n * 8 + i < chans) begin
                b[i] = img[n * 8 + i];
            end
        end
        return b;
    endfunction

    function automatic logic last_cycle(input logic [31:0] t);
        return t == 32'h0000_0000;
    endfunction

    function automatic logic [7:0] ram_pattern_at(input logic [5:0] a);
        return io_station_pkg::ram_pattern ^ {2'b00, a};
    endfunction

    // Output image bytes follow the address byte, low channels first
    function automatic logic [chans-1:0] cmd_image_of();
        logic [chans-1:0] img;
        img = '0;
        for (int i = 0; i < chans; i++) begin
            img[i] = cmd[1 + i / 8][i % 8];
        end
        return img;
    endfunction

    function automatic logic msg_ok(input logic addr_ok, input logic [7:0] check, input logic [7:0] count);
        return addr_ok && check == 8'h00 && count > 8'd1;
    endfunction

    // Pushbutton acts exactly like the reset pin
    assign restart = rst | pushbutton_reset;
    assign rx_valid = cur.chan_b ? rx_valid_b : rx_valid_a;
    assign rx_byte = cur.chan_b ? rx_byte_b : rx_byte_a;

    always_comb begin
        nxt = cur;
        ram_we = 1'b0;
        ram_waddr = '0;
        ram_wdata = 8'h00;
        resp_build = 1'b0;
        cmd_we = 1'b0;
        if (!last_cycle(cur.tx_flash)) begin
            nxt.tx_flash = cur.tx_flash - 32'd1;
        end
        if (!last_cycle(cur.rx_flash)) begin
            nxt.rx_flash = cur.rx_flash - 32'd1;
        end
        unique case (cur.phase)
            st_hw_init: begin
                nxt.idx = '0;
                nxt.sum = 8'h00;
                nxt.in_image = '0;
                nxt.out_image = '0;
                // A restart drops any half-received message
                nxt.rx_count = 8'h00;
                nxt.rx_check = 8'h00;
                nxt.rx_addr_ok = 1'b0;
                nxt.tx_busy = 1'b0;
                nxt.idle_idx = '0;
                nxt.idle_write = 1'b0;
                nxt.phase = st_ram_test;
            end
            st_ram_test: begin
                if (!cur.idx[6]) begin
                    ram_we = 1'b1;
                    ram_waddr = cur.idx[5:0];
                    ram_wdata = ram_pattern_at(cur.idx[5:0]);
                    nxt.idx = cur.idx + 7'd1;
                end else if (cur.sum[6:0] < 7'(io_station_pkg::ram_words)) begin
                    if (ram[cur.sum[5:0]] != ram_pattern_at(cur.sum[5:0])) begin
                        nxt.phase = st_halt;
                    end
                    nxt.sum = cur.sum + 8'd1;
                end else begin
                    nxt.idx = '0;
                    nxt.sum = 8'h00;
                    nxt.phase = st_rom_test;
                end
            end
            st_rom_test: begin
                // Wrapping sum of program bytes 0 to 127 must land on the expected value
                nxt.sum = cur.sum + rom_data;
                nxt.idx = cur.idx + 7'd1;
                if (cur.idx == 7'h7f) begin
                    nxt.phase = (cur.sum + rom_data == io_station_pkg::rom_sum_expected) ? st_comm_setup : st_halt;
                end
            end
            st_comm_setup: begin
                nxt.rx_count = 8'h00;
                nxt.tx_busy = 1'b0;
                nxt.comm_timer = timeout_cycles;
                nxt.phase = st_find_link;
            end
            st_find_link: begin
                // Channel A wins when both carry traffic
                if (rx_valid_a) begin
                    nxt.chan_b = 1'b0;
                    nxt.phase = st_main;
                end else if (rx_valid_b) begin
                    nxt.chan_b = 1'b1;
                    nxt.phase = st_main;
                end
                nxt.scan_timer = scan_cycles;
            end
            st_main: begin
                nxt.scan_timer = cur.scan_timer - 32'd1;
                nxt.comm_timer = cur.comm_timer - 32'd1;
                if (last_cycle(cur.comm_timer)) begin
                    nxt.phase = st_comm_setup;
                end else if (last_cycle(cur.scan_timer)) begin
                    nxt.phase = st_scan;
                end else if (!cur.idle_write) begin
                    // Write one idle cycle, read back the next: one word per two idle cycles
                    ram_we = 1'b1;
                    ram_waddr = cur.idle_idx;
                    ram_wdata = ram_pattern_at(cur.idle_idx);
                    nxt.idle_write = 1'b1;
                end else begin
                    if (ram[cur.idle_idx] != ram_pattern_at(cur.idle_idx)) begin
                        nxt.phase = st_hw_init;
                    end
                    nxt.idle_write = 1'b0;
                    nxt.idle_idx = cur.idle_idx + 6'd1;
                end
            end
            st_scan: begin
                nxt.in_image = input_channels;
                resp_build = 1'b1;
                nxt.scan_timer = scan_cycles;
                nxt.phase = cur.tx_busy ? st_respond : st_main;
            end
            st_respond: begin
                nxt.scan_timer = last_cycle(cur.scan_timer) ? 32'd0 : cur.scan_timer - 32'd1;
                nxt.comm_timer = cur.comm_timer - 32'd1;
                if (last_cycle(cur.comm_timer)) begin
                    // Master stopped taking bytes: give up and relink
                    nxt.tx_busy = 1'b0;
                    nxt.phase = st_comm_setup;
                end else if (tx_ready) begin
                    nxt.tx_flash = flash_len;
                    nxt.tx_idx = cur.tx_idx + 8'd1;
                    if (cur.tx_idx == 8'(io_station_pkg::msg_len - 1)) begin
                        nxt.tx_busy = 1'b0;
                        nxt.phase = st_main;
                    end
                end
            end
            st_halt: begin
                nxt.phase = st_halt;
            end
            default: nxt.phase = st_hw_init;
        endcase
        // Bytes are taken in the scan cycle too; bytes arriving while a response is sent (st_respond) are dropped
        if (cur.phase == st_main || cur.phase == st_scan) begin
            if (rx_valid) begin
                nxt.rx_flash = flash_len;
                cmd_we = 1'b1;
                nxt.rx_count = cur.rx_count + 8'd1;
                nxt.rx_check = cur.rx_check ^ rx_byte;
                if (cur.rx_count == 8'h00) begin
                    nxt.rx_addr_ok = rx_byte == station_address;
                end
            end
            if (rx_end) begin
                nxt.rx_count = 8'h00;
                nxt.rx_check = 8'h00;
                if (msg_ok(cur.rx_addr_ok, cur.rx_check, cur.rx_count)) begin
                    nxt.out_image = cmd_image_of();
                    nxt.comm_timer = timeout_cycles;
                    nxt.tx_idx = 8'h00;
                    nxt.tx_busy = 1'b1;
                    nxt.phase = st_respond;
                end else begin
                    nxt.rx_addr_ok = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (restart) begin
            cur <= '0;
        end else begin
            cur <= nxt;
        end
        if (ram_we) begin
            ram[ram_waddr] <= ram_wdata;
        end
        if (cmd_we && cur.rx_count < 8'(io_station_pkg::msg_len)) begin
            cmd[cur.rx_count[4:0]] <= rx_byte;
        end
        if (resp_build) begin
            resp[0] <= io_station_pkg::resp_marker;
            resp[1] <= station_address;
            for (int k = 2; k < io_station_pkg::msg_len; k++) begin
                resp[k] <= img_byte(input_channels, k - 2);
            end
        end
    end

    // outputs decoded from the registered state; scan capture and link handling share one process
    always_comb begin
        rom_addr = {1'b0, cur.idx};
        tx_valid = cur.phase == st_respond;
        tx_byte = resp[cur.tx_idx[4:0]];
        output_channels = cur.out_image;
        serial_setup = cur.phase == st_comm_setup;
        halted = cur.phase == st_halt;
        running = cur.phase == st_main || cur.phase == st_scan || cur.phase == st_respond;
        channel_select_indicator = !cur.chan_b;
        link_colour_red = !cur.chan_b;
        link_colour_green = cur.chan_b;
        transmit_activity_indicator = !last_cycle(cur.tx_flash);
        receive_activity_indicator = !last_cycle(cur.rx_flash);
        tx_activity_a = !cur.chan_b && !last_cycle(cur.tx_flash);
        rx_activity_a = !cur.chan_b && !last_cycle(cur.rx_flash);
        tx_activity_b = cur.chan_b && !last_cycle(cur.tx_flash);
        rx_activity_b = cur.chan_b && !last_cycle(cur.rx_flash);
    end
endmodule

// ### test/io_station_checker.sv
/* Port assertions for the station supervisor.
   Bound to every supervisor instance; one clock, sync reset. */
`timescale 1ns/1ps
module io_station_checker #(
    parameter int unsigned chans = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic pushbutton_reset,
    input wire logic rx_valid_a,
    input wire logic rx_end,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic tx_ready,
    input wire logic [chans-1:0] output_channels,
    input wire logic serial_setup,
    input wire logic halted,
    input wire logic running,
    input wire logic channel_select_indicator,
    input wire logic link_colour_red,
    input wire logic link_colour_green,
    input wire logic transmit_activity_indicator,
    input wire logic receive_activity_indicator,
    input wire logic tx_activity_a,
    input wire logic rx_activity_a,
    input wire logic rx_valid_b,
    input wire logic rx_activity_b
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || pushbutton_reset);
    reset_clears_a: assert property (disable iff (1'b0) rst |=> !running && !halted && !tx_valid)
        else $error("reset left state active");
    halt_latch_a: assert property (halted |=> halted && !running && !tx_valid)
        else $error("halt did not hold");
    setup_only_a: assert property (serial_setup |-> !running && !tx_valid)
        else $error("setup overlaps normal work");
    colour_follow_a: assert property (running |-> link_colour_red == channel_select_indicator
        && link_colour_green == !channel_select_indicator)
        else $error("indicators disagree with channel");
    tx_after_poll_a: assert property ($rose(tx_valid) |-> $past(rx_end))
        else $error("response without poll");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
        else $error("response byte dropped");
    out_quiet_a: assert property (!rx_end && !$past(rx_end) |=> $stable(output_channels))
        else $error("outputs moved without command");
    rx_flash_a: assert property (rx_valid_a && running && channel_select_indicator
        |-> ##[1:2] rx_activity_a && receive_activity_indicator)
        else $error("receive indicator dark");
    tx_flash_a: assert property (tx_valid && tx_ready && channel_select_indicator
        |-> ##[1:2] tx_activity_a && transmit_activity_indicator)
        else $error("transmit indicator dark");
    rx_flash_b_a: assert property (rx_valid_b && running && !channel_select_indicator
        |-> ##[1:2] rx_activity_b && receive_activity_indicator)
        else $error("channel B receive indicator dark");
endmodule
bind io_station_supervisor io_station_checker #(.chans(chans)) chk (.clk, .rst, .pushbutton_reset,
    .rx_valid_a, .rx_end, .tx_valid, .tx_byte, .tx_ready, .output_channels, .serial_setup, .halted,
    .running, .channel_select_indicator, .link_colour_red, .link_colour_green,
    .transmit_activity_indicator, .receive_activity_indicator, .tx_activity_a, .rx_activity_a,
    .rx_valid_b, .rx_activity_b);

// ### test/io_station_supervisor_tb.sv
/* Self-checking bench for the station supervisor.
   Short scan, timeout and flash counts; master model on channel A. */
`timescale 1ns/1ps
module io_station_supervisor_tb;
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] data;
        logic bad_chk;
        logic [1:0] stall;
    } row_s;
    localparam logic [7:0] own = 8'h2c;
    logic clk = 0, rst = 1, pushbutton_reset = 0, rom_bad = 0, rx_valid_b = 0;
    logic [7:0] rx_byte_b = 8'h00, rom_addr, tx_byte, rx_byte_a, chk;
    logic [15:0] input_channels = 16'hc3a5, output_channels, img = 16'h0000;
    logic rx_valid_a, rx_end, tx_valid, tx_ready, serial_setup, halted, running, sel, grn, act_b;
    wire logic [7:0] station_address = own;
    // One set bit per location makes the program sum nonzero
    wire logic [7:0] rom_data = {7'h00, rom_bad};
    int n_errors = 0, n_checks = 0;
    row_s r;
    logic [7:0] msg[$];
    row_s rows[5] = '{'{own, 16'h1234, 0, 0}, '{8'h2d, 16'h5555, 0, 0}, '{own, 16'haaaa, 1, 0},
        '{own, 16'hffff, 0, 2}, '{own, 16'h0001, 0, 1}};
    io_station_supervisor #(.chans(16), .scan_cycles(50), .timeout_cycles(2000), .flash_len(4)) DUT (
        .clk, .rst, .pushbutton_reset, .station_address, .rom_data, .rom_addr, .rx_valid_a,
        .rx_valid_b, .rx_byte_a, .rx_byte_b, .rx_end, .tx_valid, .tx_byte, .tx_ready, .input_channels,
        .output_channels, .serial_setup, .halted, .running, .channel_select_indicator(sel),
        .link_colour_red(), .link_colour_green(grn), .transmit_activity_indicator(),
        .receive_activity_indicator(), .tx_activity_a(), .rx_activity_a(), .tx_activity_b(),
        .rx_activity_b(act_b));
    poll_master pm (.clk, .rx_valid(rx_valid_a), .rx_byte(rx_byte_a), .rx_end, .tx_ready, .tx_valid,
        .tx_byte);
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run;
        if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wait_lvl(ref logic s, input logic v, input int lim);
        int w;
        for (w = 0; s !== v; w++) begin
            if (w == lim) begin
                n_errors++;
                $display("[ERR] wait expected %h", v);
                complete_run();
            end
            @(posedge clk) #1;
        end
    endtask
    function automatic logic [15:0] resp_exp(int i);
        case (i)
            0: return {8'h00, io_station_pkg::resp_marker};
            1: return {8'h00, own};
            2: return {8'h00, input_channels[7:0]};
            3: return {8'h00, input_channels[15:8]};
            default: return 16'h0000;
        endcase
    endfunction
    initial begin
        repeat (12) @(posedge clk);
        #1 rst = 0;
        check("halted", halted, 0);
        wait_lvl(serial_setup, 1, 400);
        msg = {own};
        pm.send(msg);
        wait_lvl(running, 1, 50);
        check("select", sel, 1);
        check("green", grn, 0);
        // Let a scan build the first response
        repeat (60) @(posedge clk);
        foreach (rows[i]) begin
            r = rows[i];
            chk = r.addr ^ r.data[7:0] ^ r.data[15:8] ^ {7'h00, r.bad_chk};
            msg = {r.addr, r.data[7:0], r.data[15:8], chk};
            pm.send(msg);
            if (r.addr == own && !r.bad_chk) begin
                img = r.data;
                pm.take(r.stall);
                check("resp len", 16'(pm.resp.size()), 16'd18);
                foreach (pm.resp[j]) check("resp byte", {8'h00, pm.resp[j]}, resp_exp(j));
            end else repeat (30) @(posedge clk);
            check("outputs", output_channels, img);
            check("tx idle", tx_valid, 0);
        end
        wait_lvl(serial_setup, 1, 2500);
        check("halted", halted, 0);
        @(posedge clk);
        #1 rx_valid_b = 1;
        rx_byte_b = own;
        @(posedge clk);
        #1 rx_valid_b = 0;
        rx_byte_b = ~own;
        wait_lvl(running, 1, 50);
        check("select", sel, 0);
        check("green", grn, 1);
        @(posedge clk);
        #1 rx_valid_b = 1;
        rx_byte_b = 8'h00;
        @(posedge clk);
        #1 rx_valid_b = 0;
        check("rx act b", act_b, 1);
        rom_bad = 1;
        pushbutton_reset = 1;
        @(posedge clk);
        #1 pushbutton_reset = 0;
        wait_lvl(halted, 1, 400);
        repeat (300) @(posedge clk);
        check("halted", halted, 1);
        check("running", running, 0);
        complete_run();
    end
endmodule

// ### test/poll_master.sv
/* Polling master on link channel A: sends commands, takes responses.
   Driven by bench task calls; changes lines 1 ns after the clock. */
`timescale 1ns/1ps
module poll_master (
    input wire logic clk,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic rx_end,
    output logic tx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte
);
    logic [7:0] resp[$];
    initial begin
        rx_valid = 0;
        rx_byte = 8'h00;
        rx_end = 0;
        tx_ready = 0;
    end
    task automatic send(input logic [7:0] b[$]);
        foreach (b[i]) begin
            @(posedge clk);
            #1 rx_valid = 1;
            rx_byte = b[i];
        end
        @(posedge clk);
        #1 rx_valid = 0;
        // Idle line inverted so a stale byte never matches
        rx_byte = ~rx_byte;
        rx_end = 1;
        @(posedge clk);
        #1 rx_end = 0;
    endtask
    // Stall inserts idle cycles between taken bytes
    task automatic take(input int stall);
        int w;
        resp.delete();
        for (w = 1; resp.size() < 18 && w < 400; w++) begin
            @(posedge clk);
            #1 tx_ready = (w % (stall + 1)) == 0;
            // Judged mid-cycle, before the edge that takes the byte
            @(negedge clk);
            if (tx_ready && tx_valid) resp.push_back(tx_byte);
        end
        @(posedge clk);
        #1 tx_ready = 0;
    endtask
endmodule
